// >>> hw/cwlo_chan.sv
`timescale 1ns/1ns
module cwlo_chan
    import cwlo_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Shared divider state.
    input wire logic [3:0] count,
    input cwlo_div_t div_mode,
    // Channel phase code.
    input wire logic [3:0] phase_code,
    // Retimed LO outputs.
    output logic lo_i,
    output logic lo_q
);
    logic next_lo_i;
    logic next_lo_q;
    logic [3:0] mask;
    logic [3:0] half;
    logic [3:0] pos;
    logic [3:0] qpos;

    always_comb begin
        mask = cwlo_mask(div_mode);
        half = (mask >> 1) + 4'h1;
        // A higher code advances the position, so that channel leads.
        pos = (count + (phase_code >> cwlo_shift(div_mode))) & mask;
        // Quarter-period lag taken from evenly spaced counter states.
        qpos = (pos - (half >> 1)) & mask;
        next_lo_i = pos < half;
        next_lo_q = qpos < half;
    end

    // Last flops run straight off the master LO so counter decode glitches never reach the pins.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            lo_i <= 1'b0;
            lo_q <= 1'b0;
        end else begin
            lo_i <= next_lo_i;
            lo_q <= next_lo_q;
        end
    end
endmodule : cwlo_chan

// >>> hw/cwlo_gen.sv
`timescale 1ns/1ns
module cwlo_gen
    import cwlo_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Master LO clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port.
    input cwlo_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Trigger and divider sync pins.
    input wire logic transmit_trigger_input,
    input wire logic divider_sync_input,
    // Trigger event pulses.
    output cwlo_trig_t trig_out,
    // Analog test tone level.
    output logic [1:0] test_tone_level,
    // Per-channel quadrature LO.
    output logic [CHANNELS-1:0] lo_i,
    output logic [CHANNELS-1:0] lo_q
);
    logic [7:0] divcfg, next_divcfg;
    logic [7:0] trigreg, next_trigreg;
    logic [7:0] tonereg, next_tonereg;
    logic [7:0] chmask, next_chmask;
    logic [3:0] phase [CHANNELS];
    logic [3:0] next_phase [CHANNELS];
    logic [7:0] next_rdata;
    logic [1:0] next_tone_level;
    logic [3:0] count, next_count;
    logic trig_q, next_trig_q;
    logic sync_q, next_sync_q;
    logic sync_qq, next_sync_qq;
    logic sw_trig, hw_trig;
    cwlo_trig_t next_trig_out;
    cwlo_div_t div_mode, next_div_mode;
    logic sync_edge;
    logic [3:0] first_phase;

    always_comb begin
        sw_trig = reg_req.wr && reg_req.addr == CWLO_ADDR_TRIG
            && reg_req.wdata[CWLO_SWTRIG_BIT];
        next_divcfg = divcfg;
        next_trigreg = trigreg;
        next_tonereg = tonereg;
        next_chmask = chmask;
        next_phase = phase;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                CWLO_ADDR_DIVCFG: next_divcfg = reg_req.wdata;
                CWLO_ADDR_TONE: next_tonereg = reg_req.wdata;
                CWLO_ADDR_CHMASK: next_chmask = reg_req.wdata;
                CWLO_ADDR_TRIG: begin
                    // The trigger bit is a strobe and never stays set.
                    next_trigreg = reg_req.wdata;
                    next_trigreg[CWLO_SWTRIG_BIT] = 1'b0;
                end
                CWLO_ADDR_PHASE: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        if (chmask[c]) begin
                            next_phase[c] = reg_req.wdata[CWLO_PHASE_LSB +: 4];
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        first_phase = CWLO_RST_PHASE;
        for (int c = CHANNELS - 1; c >= 0; c--) begin
            if (chmask[c]) begin
                first_phase = phase[c];
            end
        end
        next_rdata = CWLO_RST_REG;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                CWLO_ADDR_DIVCFG: next_rdata = divcfg;
                CWLO_ADDR_TONE: next_rdata = tonereg;
                CWLO_ADDR_CHMASK: next_rdata = chmask;
                CWLO_ADDR_TRIG: next_rdata = trigreg;
                CWLO_ADDR_PHASE: next_rdata = {4'h0, first_phase};
                default: next_rdata = CWLO_RST_REG;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            divcfg <= CWLO_RST_REG;
            trigreg <= CWLO_RST_REG;
            tonereg <= CWLO_RST_REG;
            chmask <= CWLO_RST_CHMASK;
            reg_rdata <= CWLO_RST_REG;
            for (int c = 0; c < CHANNELS; c++) begin
                phase[c] <= CWLO_RST_PHASE;
            end
        end else begin
            divcfg <= next_divcfg;
            trigreg <= next_trigreg;
            tonereg <= next_tonereg;
            chmask <= next_chmask;
            reg_rdata <= next_rdata;
            phase <= next_phase;
        end
    end

    // Tone level; the reserved code leaves the previous level in force.
    always_comb begin
        next_tone_level = test_tone_level;
        unique case (tonereg[CWLO_TONE_LSB +: 2])
            CWLO_TONE_X1, CWLO_TONE_X2, CWLO_TONE_X4: begin
                next_tone_level = tonereg[CWLO_TONE_LSB +: 2];
            end
            CWLO_TONE_RSVD: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            test_tone_level <= CWLO_TONE_X1;
        end else begin
            test_tone_level <= next_tone_level;
        end
    end

    // Trigger: the pin is sampled every edge so all devices see it on the same one.
    always_comb begin
        next_trig_q = transmit_trigger_input;
        hw_trig = transmit_trigger_input && !trig_q;
        next_trig_out.demod_reset = hw_trig || sw_trig;
        next_trig_out.power_seq_start = hw_trig || sw_trig;
        next_trig_out.framing_align = hw_trig || sw_trig;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            trig_q <= 1'b0;
            trig_out <= '0;
        end else begin
            trig_q <= next_trig_q;
            trig_out <= next_trig_out;
        end
    end

    // Divider. Falling-edge sampling is modelled as a half-cycle later capture,
    // which in a single clock domain lands one rising edge later.
    always_comb begin
        unique case (divcfg[CWLO_DIV_LSB +: 3])
            CWLO_DIV_CODE_4: next_div_mode = CWLO_DIV4;
            CWLO_DIV_CODE_8: next_div_mode = CWLO_DIV8;
            default: next_div_mode = CWLO_DIV16;
        endcase
        next_sync_q = divider_sync_input;
        next_sync_qq = sync_q;
        if (divcfg[CWLO_SYNC_EDGE_BIT]) begin
            sync_edge = sync_q && !sync_qq;
        end else begin
            sync_edge = divider_sync_input && !sync_q;
        end
        if (sync_edge) begin
            next_count = CWLO_COUNT_SYNC;
        end else begin
            next_count = (count + 4'h1) & cwlo_mask(div_mode);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_mode <= CWLO_DIV4;
            sync_q <= 1'b0;
            sync_qq <= 1'b0;
            count <= CWLO_COUNT_SYNC;
        end else begin
            div_mode <= next_div_mode;
            sync_q <= next_sync_q;
            sync_qq <= next_sync_qq;
            count <= next_count;
        end
    end

    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        cwlo_chan u_chan (
            .clk(clk),
            .nrst(nrst),
            .count(count),
            .div_mode(div_mode),
            .phase_code(phase[c]),
            .lo_i(lo_i[c]),
            .lo_q(lo_q[c])
        );
    end
endmodule : cwlo_gen

// >>> hw/cwlo_pkg.sv
package cwlo_pkg;
    // Register indexes on the register port.
    localparam logic [11:0] CWLO_ADDR_PHASE = 12'h02d;
    localparam logic [11:0] CWLO_ADDR_DIVCFG = 12'h02e;
    localparam logic [11:0] CWLO_ADDR_TRIG = 12'h10c;
    localparam logic [11:0] CWLO_ADDR_TONE = 12'h116;
    localparam logic [11:0] CWLO_ADDR_CHMASK = 12'h005;

    // Field positions.
    localparam int CWLO_PHASE_LSB = 0;
    localparam int CWLO_DIV_LSB = 0;
    localparam int CWLO_SYNC_EDGE_BIT = 3;
    localparam int CWLO_SWTRIG_BIT = 5;
    localparam int CWLO_TONE_LSB = 2;

    // Reset values.
    localparam logic [7:0] CWLO_RST_REG = 8'h00;
    localparam logic [7:0] CWLO_RST_CHMASK = 8'hff;
    localparam logic [3:0] CWLO_RST_PHASE = 4'h0;
    localparam logic [3:0] CWLO_COUNT_SYNC = 4'h0;

    // Divider select codes.
    localparam logic [2:0] CWLO_DIV_CODE_4 = 3'h0;
    localparam logic [2:0] CWLO_DIV_CODE_8 = 3'h1;
    localparam logic [2:0] CWLO_DIV_CODE_16 = 3'h2;

    // Test tone level codes.
    localparam logic [1:0] CWLO_TONE_X1 = 2'h0;
    localparam logic [1:0] CWLO_TONE_X2 = 2'h1;
    localparam logic [1:0] CWLO_TONE_X4 = 2'h2;
    localparam logic [1:0] CWLO_TONE_RSVD = 2'h3;

    typedef enum logic [1:0] {
        CWLO_DIV4,
        CWLO_DIV8,
        CWLO_DIV16
    } cwlo_div_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } cwlo_reg_req_t;

    typedef struct packed {
        logic demod_reset;
        logic power_seq_start;
        logic framing_align;
    } cwlo_trig_t;

    // Counter mask (M - 1) for a divider mode.
    function automatic logic [3:0] cwlo_mask(input cwlo_div_t m);
        unique case (m)
            CWLO_DIV4: cwlo_mask = 4'h3;
            CWLO_DIV8: cwlo_mask = 4'h7;
            CWLO_DIV16: cwlo_mask = 4'hf;
        endcase
    endfunction : cwlo_mask

    // Right shift that turns a 16-step phase code into divider counts.
    function automatic logic [1:0] cwlo_shift(input cwlo_div_t m);
        unique case (m)
            CWLO_DIV4: cwlo_shift = 2'h2;
            CWLO_DIV8: cwlo_shift = 2'h1;
            CWLO_DIV16: cwlo_shift = 2'h0;
        endcase
    endfunction : cwlo_shift
endpackage : cwlo_pkg

// >>> verification/cwlo_ctrl.sv
`timescale 1ns/1ns
module cwlo_ctrl (
    // Master LO clock.
    input wire logic clk,
    // Pins into the device.
    output logic transmit_trigger_input,
    output logic divider_sync_input
);
    // Unused pins rest low.
    initial begin
        transmit_trigger_input = 1'b0;
        divider_sync_input = 1'b0;
    end
    task automatic drive_trig(input logic v);
        @(posedge clk);
        #1 transmit_trigger_input = v;
    endtask : drive_trig
    // Sync changes just after a rising edge, so it is aligned to the LO.
    task automatic drive_sync(input logic v);
        @(posedge clk);
        #1 divider_sync_input = v;
    endtask : drive_sync
endmodule : cwlo_ctrl

// >>> verification/cwlo_gen_props.sv
`timescale 1ns/1ns
module cwlo_gen_props
    import cwlo_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port.
    input cwlo_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Pins and outputs.
    input wire logic transmit_trigger_input,
    input wire logic divider_sync_input,
    input cwlo_trig_t trig_out,
    input wire logic [1:0] test_tone_level,
    input wire logic [CHANNELS-1:0] lo_i,
    input wire logic [CHANNELS-1:0] lo_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [2:0] div_code;
    logic [4:0] quiet;
    logic sw_trig;
    logic tone_wr;
    assign sw_trig = reg_req.wr && reg_req.addr == CWLO_ADDR_TRIG && reg_req.wdata[5];
    assign tone_wr = reg_req.wr && reg_req.addr == CWLO_ADDR_TONE;
    // Any write or sync edge may move the LO, so the waves are judged only once settled.
    always_ff @(posedge clk) begin
        if (!nrst || reg_req.wr || $rose(divider_sync_input)) begin
            quiet <= 5'h00;
        end else if (quiet != 5'h1f) begin
            quiet <= quiet + 5'h01;
        end
        if (!nrst) begin
            div_code <= 3'h0;
        end else if (reg_req.wr && reg_req.addr == CWLO_ADDR_DIVCFG) begin
            div_code <= reg_req.wdata[2:0];
        end
    end
    trig_pin_a: assert property ($rose(transmit_trigger_input) |=> trig_out == 3'h7)
        else $error("pin trigger gave no pulse");
    trig_sw_a: assert property (sw_trig |=> trig_out == 3'h7)
        else $error("software trigger gave no pulse");
    trig_quiet_a: assert property ($past(nrst) && !$rose(transmit_trigger_input) && !sw_trig
        |=> trig_out == 3'h0) else $error("trigger pulse without cause");
    // The level is registered from the stored field, so it lands two edges after the write.
    tone_set_a: assert property (tone_wr && reg_req.wdata[3:2] != 2'h3
        |=> ##1 test_tone_level == $past(reg_req.wdata[3:2], 2))
        else $error("tone level wrong");
    tone_rsvd_a: assert property (tone_wr && reg_req.wdata[3:2] == 2'h3
        |=> ##1 $stable(test_tone_level)) else $error("reserved tone changed level");
    trig_bit_a: assert property (reg_req.rd && reg_req.addr == CWLO_ADDR_TRIG
        |=> !reg_rdata[5]) else $error("trigger bit reads one");
    rdata_idle_a: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
    lo_period_a: assert property (quiet == 5'h1f |-> lo_i == (div_code == 3'h0 ? $past(lo_i, 4)
        : div_code == 3'h1 ? $past(lo_i, 8) : $past(lo_i, 16))) else $error("LO period wrong");
    quad_lag_a: assert property (quiet == 5'h1f |-> lo_q == (div_code == 3'h0 ? $past(lo_i)
        : div_code == 3'h1 ? $past(lo_i, 2) : $past(lo_i, 4))) else $error("Q lag wrong");
endmodule : cwlo_gen_props
bind cwlo_gen cwlo_gen_props #(.CHANNELS(CHANNELS)) u_props (.clk(clk), .nrst(nrst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .transmit_trigger_input(transmit_trigger_input),
    .divider_sync_input(divider_sync_input), .trig_out(trig_out),
    .test_tone_level(test_tone_level), .lo_i(lo_i), .lo_q(lo_q));

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    import cwlo_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    cwlo_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic trig_pin;
    logic sync_pin;
    cwlo_trig_t trig_out;
    logic [1:0] test_tone_level;
    logic [7:0] lo_i;
    logic [7:0] lo_q;
    logic [7:0] exp_i;
    logic [7:0] exp_q;
    logic [3:0] code [8];
    int num_errors = 0;
    int num_checks = 0;
    int mm;
    int pos;
    always #10 clk = ~clk;
    cwlo_ctrl ctrl (.clk(clk), .transmit_trigger_input(trig_pin), .divider_sync_input(sync_pin));
    cwlo_gen #(.CHANNELS(8)) DUT (.clk(clk), .nrst(nrst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .transmit_trigger_input(trig_pin),
        .divider_sync_input(sync_pin), .trig_out(trig_out),
        .test_tone_level(test_tone_level), .lo_i(lo_i), .lo_q(lo_q));
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 reg_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 reg_req.rd = 1'b0;
        `CHK("rdata", e, reg_rdata)
    endtask : rd
    // Counts full trigger pulses over four cycles, starting with the present one.
    task automatic count_trig(input int want);
        int n;
        n = 0;
        repeat (4) begin
            n += int'(trig_out === 3'h7);
            @(posedge clk);
            #1;
        end
        `CHK("trig pulses", want, n)
    endtask : count_trig
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        rd(CWLO_ADDR_PHASE, 8'h00);
        rd(CWLO_ADDR_DIVCFG, 8'h00);
        rd(CWLO_ADDR_TRIG, 8'h00);
        rd(CWLO_ADDR_TONE, 8'h00);
        rd(12'h7ff, 8'h00);
        rd(CWLO_ADDR_CHMASK, 8'hff);
        for (int t = 0; t < 4; t++) begin
            wr(CWLO_ADDR_TONE, 8'(t << 2));
            // The level output follows the stored field one edge later.
            @(posedge clk);
            #1;
            `CHK("tone", 2'(t == 3 ? 2 : t), test_tone_level)
        end
        ctrl.drive_trig(1'b1);
        count_trig(1);
        ctrl.drive_trig(1'b0);
        count_trig(0);
        wr(CWLO_ADDR_TRIG, 8'h25);
        count_trig(1);
        rd(CWLO_ADDR_TRIG, 8'h05);
        for (int m = 0; m < 3; m++) begin
            mm = 4 << m;
            wr(CWLO_ADDR_DIVCFG, 8'(m) | (m == 1 ? 8'h08 : 8'h00));
            for (int ch = 0; ch < 8; ch++) begin
                code[ch] = 4'(2 * ch + int'(m == 2));
                wr(CWLO_ADDR_CHMASK, 8'h01 << ch);
                wr(CWLO_ADDR_PHASE, {4'h0, code[ch]});
            end
            rd(CWLO_ADDR_PHASE, {4'h0, code[7]});
            ctrl.drive_sync(1'b1);
            ctrl.drive_sync(1'b0);
            // The falling-edge option takes the sync one cycle later.
            repeat (int'(m == 1)) @(posedge clk);
            for (int k = 0; k < 2 * mm; k++) begin
                @(posedge clk);
                #1;
                for (int ch = 0; ch < 8; ch++) begin
                    pos = (k + (int'(code[ch]) >> (2 - m))) % mm;
                    exp_i[ch] = pos < mm / 2;
                    exp_q[ch] = (pos + mm - mm / 4) % mm < mm / 2;
                end
                `CHK("lo_i", exp_i, lo_i)
                `CHK("lo_q", exp_q, lo_q)
            end
            // Idle time lets the period and lag assertions judge every mode.
            repeat (32) @(posedge clk);
        end
        // A second reset in mid-run must bring the divider config, channel mask and tone level back to their defaults.
        @(posedge clk);
        #1 nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        rd(CWLO_ADDR_DIVCFG, 8'h00);
        rd(CWLO_ADDR_CHMASK, 8'hff);
        `CHK("tone after reset", CWLO_TONE_X1, test_tone_level)
        end_of_test();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule : tb_top
